// file: wdc_pkg.sv
// Summary of operation
// - 32-bit hardware breakpoint: address mask bits 1:0 set
// - 16-bit hardware breakpoint: only address mask bit0 set
// - Data mask all ones, or zeros when data-dependent
// - Fetch breakpoint: fetch bit clear, other mask bits set
// - Software breakpoint: address mask ones, data mask zero
// - 16-bit pattern repeated in both data halves
// - Data watchpoint: watched address, address mask zero
// - Watchpoint mask: fetch, direction, size bits clear
// - User-mode and other control bits programmed alike
// - Program comparators only while core is halted
// - Save instruction, write pattern, later restore it
// - 38-bit scan access, effective on Update-DR entry
package wdc_pkg;
    // Link timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TCK_PERIOD_NS = 400;
    localparam int TCK_CYCLES = (TCK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Scan chain shape
    localparam int SCAN_LEN = 38;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 5;
    localparam logic [5:0] RESET_WALK_LAST = 6'h05;
    localparam logic [5:0] SCAN_LEN_M1 = 6'h25;
    localparam logic [4:0] WP_FIRST_ADDR = 5'h08;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_WDATA = 8'h04;
    localparam logic [7:0] OFF_RDATA = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_PRESET = 8'h10;
    localparam logic [7:0] OFF_SAVE = 8'h14;
    localparam logic [7:0] OFF_CFG = 8'h18;
    // Command fields
    localparam int CMD_GO = 0;
    localparam int CMD_IR = 1;
    localparam int CMD_RW = 2;
    localparam int CMD_ADDR_LO = 3;
    localparam int CMD_LEN_LO = 8;
    localparam int CMD_IDLE_LO = 14;
    localparam int CMD_W = 22;
    localparam logic [CMD_W-1:0] CMD_RESET = 22'h000000;
    // Status and config bits
    localparam int STS_BUSY = 0;
    localparam int STS_DONE = 1;
    localparam int STS_REFUSED = 2;
    localparam int STS_HALT = 3;
    localparam logic CFG_GUARD_RESET = 1'b1;
    // Watchpoint control bit layout and preset values
    localparam logic [31:0] CTL_FETCH = 32'h00000008;
    localparam logic [31:0] CTL_USER = 32'h00000010;
    localparam logic [31:0] CTL_ENABLE = 32'h00000100;
    localparam logic [31:0] PV_MASK_WORD = 32'h00000003;
    localparam logic [31:0] PV_MASK_HALF = 32'h00000001;
    localparam logic [31:0] PV_ONES = 32'hffffffff;
    localparam logic [31:0] PV_ZEROS = 32'h00000000;
    localparam logic [31:0] PV_FETCH_CMASK = 32'h000000f7;
    localparam logic [31:0] PV_WATCH_CMASK = 32'h000000f0;
    typedef enum logic [3:0] {
        PR_MASK_WORD = 4'h0, PR_MASK_HALF = 4'h1, PR_ONES = 4'h2, PR_ZEROS = 4'h3,
        PR_FETCH_CMASK = 4'h4, PR_FETCH_CVAL = 4'h5, PR_WATCH_CMASK = 4'h6,
        PR_DUP_HALF = 4'h7, PR_SAVE = 4'h8, PR_RESTORE = 4'h9, PR_USER = 4'ha,
        PR_WATCH_CVAL = 4'hb
    } wdc_preset_type;
    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_SEL_IR = 4'h3,
        ST_CAPT = 4'h4, ST_ENTER = 4'h5, ST_SHIFT = 4'h6, ST_EXIT = 4'h7,
        ST_UPD = 4'h8, ST_RTI = 4'h9
    } wdc_state_type;
endpackage

// file: wdc_scan_if.sv
`timescale 1ns/100ps
interface wdc_scan_if;
    logic start;
    logic ir_sel;
    logic [5:0] len_m1;
    logic [37:0] vec;
    logic [7:0] idle_tcks;
    logic busy;
    logic done;
    logic [37:0] result;
    modport ctl(output start, ir_sel, len_m1, vec, idle_tcks, input busy, done, result);
    modport eng(input start, ir_sel, len_m1, vec, idle_tcks, output busy, done, result);
endinterface

// file: wdc_scan_engine.sv
`timescale 1ns/100ps
module wdc_scan_engine import wdc_pkg::*; #(
    parameter int TCK_PHASES = TCK_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    wdc_scan_if.eng sc,
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo
);
    localparam int PW = $clog2(TCK_PHASES);
    localparam logic [PW-1:0] PH_LAST = PW'(TCK_PHASES - 1);
    localparam logic [PW-1:0] PH_HALF = PW'(TCK_PHASES / 2);

    // The TDO sample point needs two sync cycles after the falling edge
    if (TCK_PHASES < 4 || (TCK_PHASES % 2) != 0) begin : g_bad_div
        $error("TCK_PHASES must be even and at least 4");
    end

    wdc_state_type state_reg, state_next;
    logic [PW-1:0] phase_reg, phase_next;
    logic [5:0] cnt_reg, cnt_next;
    logic [7:0] idle_reg;
    logic pend_reg, ir_reg, tdo_meta, tdo_sync, done_reg, tms_next;
    logic [5:0] len_reg;
    logic [37:0] vec_reg, res_reg;
    logic tick;

    assign tick = phase_reg == PH_LAST;
    assign phase_next = tick ? '0 : phase_reg + 1'b1;
    assign sc.busy = (state_reg != ST_IDLE) || pend_reg;
    assign sc.done = done_reg;
    assign sc.result = res_reg;

    // TDO from the far clock domain
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tdo_meta <= 1'b0;
            tdo_sync <= 1'b0;
        end else begin
            tdo_meta <= i_tdo;
            tdo_sync <= tdo_meta;
        end
    end

    // TAP walk; state moves at most once per TCK period
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: state_next = (cnt_reg == RESET_WALK_LAST) ? ST_IDLE : ST_RESET;
            ST_IDLE: state_next = pend_reg ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_next = ir_reg ? ST_SEL_IR : ST_CAPT;
            ST_SEL_IR: state_next = ST_CAPT;
            ST_CAPT: state_next = ST_ENTER;
            ST_ENTER: state_next = ST_SHIFT;
            ST_SHIFT: state_next = (cnt_reg == len_reg) ? ST_EXIT : ST_SHIFT;
            ST_EXIT: state_next = ST_UPD;
            ST_UPD: state_next = (idle_reg == 8'h00) ? ST_IDLE : ST_RTI;
            ST_RTI: state_next = (idle_reg == 8'h01) ? ST_IDLE : ST_RTI;
            default: state_next = ST_IDLE;
        endcase
        cnt_next = (state_next == state_reg) ? cnt_reg + 6'h01 : 6'h00;
        case (state_next)
            ST_RESET: tms_next = cnt_next != RESET_WALK_LAST;
            ST_SEL_DR, ST_SEL_IR, ST_EXIT: tms_next = 1'b1;
            ST_SHIFT: tms_next = cnt_next == len_reg; // Last bit leaves Shift
            default: tms_next = 1'b0;
        endcase
    end

    // Sequencer and pin registers
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_RESET;
            phase_reg <= '0;
            cnt_reg <= 6'h00;
            o_tck <= 1'b0;
            o_tms <= 1'b1;
            o_tdi <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            o_tck <= (state_reg != ST_IDLE) && (phase_next >= PH_HALF);
            done_reg <= tick && state_next == ST_IDLE
                && (state_reg == ST_UPD || state_reg == ST_RTI);
            if (tick) begin
                state_reg <= state_next;
                cnt_reg <= cnt_next;
                o_tms <= tms_next;
                o_tdi <= (state_next == ST_SHIFT) ? vec_reg[cnt_next] : 1'b0;
            end
        end
    end

    // Command capture; a start while busy is dropped
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pend_reg <= 1'b0;
            ir_reg <= 1'b0;
            len_reg <= SCAN_LEN_M1;
            vec_reg <= '0;
            idle_reg <= 8'h00;
        end else if (sc.start && !sc.busy) begin
            pend_reg <= 1'b1;
            ir_reg <= sc.ir_sel;
            len_reg <= sc.len_m1;
            vec_reg <= sc.vec;
            idle_reg <= sc.idle_tcks;
        end else begin
            if (tick && state_reg == ST_IDLE) begin
                pend_reg <= 1'b0;
            end
            if (tick && state_reg == ST_RTI) begin
                idle_reg <= idle_reg - 8'h01;
            end
        end
    end

    // Captured bits, sampled just before TCK falls
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            res_reg <= '0;
        end else if (tick && state_reg == ST_SHIFT) begin
            res_reg[cnt_reg] <= tdo_sync;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_idle_tck_low: assert property (state_reg == ST_IDLE && !pend_reg |=> !o_tck)
        else $error("TCK toggled while idle");
    a_rti_tms_low: assert property (state_reg == ST_RTI |-> !o_tms)
        else $error("TMS high while holding Run-Test/Idle");
    a_exit_to_update: assert property (state_reg == ST_EXIT |-> o_tms)
        else $error("Update-DR not entered after Exit1");
endmodule

// file: wdc_host_top.sv
`timescale 1ns/100ps
module wdc_host_top import wdc_pkg::*; #(
    parameter int TCK_PHASES = TCK_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo,
    input wire logic i_halt_acknowledge
);
    wdc_scan_if sc();

    logic [CMD_W-1:0] cmd_reg;
    logic [31:0] wdata_reg, rdata_reg, save_reg, rd_mux;
    logic done_reg, refused_reg, guard_reg;
    logic halt_meta, halt_sync;
    logic req, wr_take, cmd_go, refuse, start_reg;
    logic [4:0] cmd_addr;
    logic [3:0] preset_code;

    wdc_scan_engine #(.TCK_PHASES(TCK_PHASES)) u_engine (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .sc(sc),
        .o_tck(o_tck),
        .o_tms(o_tms),
        .o_tdi(o_tdi),
        .i_tdo(i_tdo)
    );

    // Halt acknowledge pin from the target
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            halt_meta <= 1'b0;
            halt_sync <= 1'b0;
        end else begin
            halt_meta <= i_halt_acknowledge;
            halt_sync <= halt_meta;
        end
    end

    // Classic slave: ack one cycle after the strobe, writes land on the ack edge
    assign req = i_wb_cyc && i_wb_stb;
    assign wr_take = req && o_wb_ack && i_wb_we;
    assign cmd_go = wr_take && i_wb_adr == OFF_CMD && i_wb_sel[0] && i_wb_dat[CMD_GO];
    assign cmd_addr = i_wb_dat[CMD_ADDR_LO +: ADDR_W];
    assign preset_code = i_wb_dat[3:0];

    // Comparator programming is refused while the core still runs
    assign refuse = cmd_go && guard_reg && !halt_sync && !i_wb_dat[CMD_IR]
        && i_wb_dat[CMD_RW] && cmd_addr >= WP_FIRST_ADDR
        && i_wb_dat[CMD_LEN_LO +: 6] == SCAN_LEN_M1;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= req && !o_wb_ack;
            if (req && !o_wb_ack) begin
                o_wb_dat <= rd_mux;
            end
        end
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        case (i_wb_adr)
            OFF_CMD: rd_mux = {10'h000, cmd_reg[CMD_W-1:1], 1'b0};
            OFF_WDATA: rd_mux = wdata_reg;
            OFF_RDATA: rd_mux = rdata_reg;
            OFF_STATUS: rd_mux = {28'h0000000, halt_sync, refused_reg, done_reg, sc.busy};
            OFF_SAVE: rd_mux = save_reg;
            OFF_CFG: rd_mux = {31'h00000000, guard_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Command register; held while a scan runs so fields stay stable
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cmd_reg <= CMD_RESET;
            start_reg <= 1'b0;
        end else begin
            start_reg <= cmd_go && !refuse && !sc.busy;
            if (wr_take && i_wb_adr == OFF_CMD && !sc.busy) begin
                cmd_reg <= i_wb_dat[CMD_W-1:0];
            end
        end
    end

    // Scan vector: data first out, address, then the read/write bit
    assign sc.start = start_reg;
    assign sc.ir_sel = cmd_reg[CMD_IR];
    assign sc.len_m1 = cmd_reg[CMD_LEN_LO +: 6];
    assign sc.idle_tcks = cmd_reg[CMD_IDLE_LO +: 8]; // Apply request in Run-Test/Idle
    assign sc.vec = cmd_reg[CMD_IR] ? {6'h00, wdata_reg}
        : {cmd_reg[CMD_RW], cmd_reg[CMD_ADDR_LO +: ADDR_W], wdata_reg};

    // Write data with recipe presets for comparator setup
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wdata_reg <= 32'h00000000;
        end else if (wr_take && i_wb_adr == OFF_WDATA) begin
            for (int b = 0; b < 4; b++) begin
                if (i_wb_sel[b]) begin
                    wdata_reg[8*b +: 8] <= i_wb_dat[8*b +: 8];
                end
            end
        end else if (wr_take && i_wb_adr == OFF_PRESET && i_wb_sel[0]) begin
            case (preset_code)
                PR_MASK_WORD: wdata_reg <= PV_MASK_WORD;
                PR_MASK_HALF: wdata_reg <= PV_MASK_HALF;
                PR_ONES: wdata_reg <= PV_ONES; // Ignore data or address
                PR_ZEROS: wdata_reg <= PV_ZEROS; // Exact match masks
                PR_FETCH_CMASK: wdata_reg <= PV_FETCH_CMASK;
                PR_FETCH_CVAL: wdata_reg <= CTL_ENABLE; // Fetch bit left clear
                PR_WATCH_CMASK: wdata_reg <= PV_WATCH_CMASK;
                PR_DUP_HALF: wdata_reg <= {wdata_reg[15:0], wdata_reg[15:0]};
                PR_RESTORE: wdata_reg <= save_reg; // Put the saved opcode back
                PR_USER: wdata_reg <= wdata_reg | CTL_USER;
                PR_WATCH_CVAL: wdata_reg <= CTL_ENABLE | CTL_FETCH
                    | {29'h00000000, wdata_reg[2:0]}; // Keep direction and size
                default: wdata_reg <= wdata_reg;
            endcase
        end
    end

    // Saved instruction for software breakpoints
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            save_reg <= 32'h00000000;
        end else if (wr_take && i_wb_adr == OFF_PRESET && i_wb_sel[0]
            && preset_code == PR_SAVE) begin
            save_reg <= rdata_reg;
        end else if (wr_take && i_wb_adr == OFF_SAVE) begin
            save_reg <= i_wb_dat;
        end
    end

    // Read-back data of the last scan
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_reg <= 32'h00000000;
        end else if (sc.done) begin
            rdata_reg <= sc.result[DATA_W-1:0];
        end
    end

    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            done_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            if (sc.done) begin
                done_reg <= 1'b1;
            end else if (wr_take && i_wb_adr == OFF_STATUS && i_wb_dat[STS_DONE]) begin
                done_reg <= 1'b0;
            end
            if (refuse) begin
                refused_reg <= 1'b1;
            end else if (wr_take && i_wb_adr == OFF_STATUS && i_wb_dat[STS_REFUSED]) begin
                refused_reg <= 1'b0;
            end
        end
    end

    // Guard enable; off when debug clocks share one source
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            guard_reg <= CFG_GUARD_RESET;
        end else if (wr_take && i_wb_adr == OFF_CFG && i_wb_sel[0]) begin
            guard_reg <= i_wb_dat[0];
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_preset(logic [3:0] code);
        wr_take && i_wb_adr == OFF_PRESET && i_wb_sel[0] && preset_code == code;
    endsequence

    a_word_mask_preset: assert property (s_preset(PR_MASK_WORD) |=> wdata_reg == 32'h3)
        else $error("Word breakpoint mask wrong");
    a_half_mask_preset: assert property (s_preset(PR_MASK_HALF) |=> wdata_reg == 32'h1)
        else $error("Halfword breakpoint mask wrong");
    a_ignore_mask_preset: assert property (s_preset(PR_ONES) |=> &wdata_reg)
        else $error("All-ones mask not loaded");
    a_fetch_cmask_preset: assert property (
        s_preset(PR_FETCH_CMASK) |=> !wdata_reg[3] && wdata_reg[7:0] == 8'hf7)
        else $error("Fetch control mask wrong");
    a_dup_half_preset: assert property (
        s_preset(PR_DUP_HALF) |=> wdata_reg[31:16] == wdata_reg[15:0]
            && wdata_reg[15:0] == $past(wdata_reg[15:0]))
        else $error("Halfword pattern not repeated");
    a_watch_cval_preset: assert property (
        s_preset(PR_WATCH_CVAL) |=> wdata_reg[8] && wdata_reg[3]
            && wdata_reg[2:0] == $past(wdata_reg[2:0]))
        else $error("Watch control value wrong");
    a_guard_refuses: assert property (
        refuse && !sc.busy |=> refused_reg && !start_reg ##1 !sc.busy)
        else $error("Comparator write not refused while running");
    a_restore_saved: assert property (
        s_preset(PR_RESTORE) |=> wdata_reg == $past(save_reg))
        else $error("Saved instruction not restored");
    a_done_reaches_status: assert property (
        sc.done |=> done_reg && rdata_reg == $past(sc.result[31:0]))
        else $error("Scan result not reported");
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("Ack held longer than one cycle");

    c_scan_done: cover property (start_reg ##[1:1000] sc.done);
    c_refused: cover property (refuse);
    c_save_restore: cover property (s_preset(PR_SAVE) ##[1:50] s_preset(PR_RESTORE));
endmodule

// file: wdc_dbg_model.sv
`timescale 1ns/100ps
module wdc_dbg_model (
    input wire logic i_rst,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic i_core_ack,
    input wire logic i_halt_request_in,
    input wire logic [31:0] i_probe_addr,
    output logic o_halt_match,
    output logic o_tdo,
    output logic o_halt_acknowledge,
    output logic o_halt_request_combined,
    output logic o_core_irq_gate
);
    // Tap moves for tms high and tms low, indexed by state
    localparam int T1 [16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
    localparam int T0 [16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 1, 11, 11, 13, 13, 11, 1};
    int tap_reg;
    logic [37:0] shift_reg;
    logic [31:0] read_reg;
    logic [2:0] ctrl_reg;
    logic req_sync_reg;
    logic [31:0] regs [32];
    // Tap, scan chain and register file on the link clock
    always_ff @(posedge i_tck or posedge i_rst) begin
        if (i_rst) begin
            tap_reg <= 0;
            ctrl_reg <= 3'h0;
            req_sync_reg <= 1'b0;
            read_reg <= 32'h00000000;
        end else begin
            tap_reg <= i_tms ? T1[tap_reg] : T0[tap_reg];
            if (tap_reg == 3) shift_reg <= {6'h00, read_reg};
            if (tap_reg == 4) shift_reg <= {i_tdi, shift_reg[37:1]};
            // Access on entry to update, no clock-stop check for control
            if ((tap_reg == 5 || tap_reg == 7) && i_tms) begin
                if (shift_reg[37] && shift_reg[36:32] == 5'h00) ctrl_reg <= shift_reg[2:0];
                else if (shift_reg[37]) regs[shift_reg[36:32]] <= shift_reg[31:0];
                else if (shift_reg[36:32] == 5'h00) read_reg <= {29'h0, ctrl_reg};
                else read_reg <= regs[shift_reg[36:32]];
            end
            // Latch opens only in run-test/idle so several cores halt together
            if (tap_reg == 1) req_sync_reg <= ctrl_reg[1];
        end
    end
    // Released output shows the inverse, never a stale copy
    always_ff @(negedge i_tck or posedge i_rst) begin
        if (i_rst) begin
            o_tdo <= 1'b0;
        end else begin
            o_tdo <= (tap_reg == 4) ? shift_reg[0] : ~o_tdo;
        end
    end
    // Watchpoint 0 address compare; a mask bit of one always matches
    assign o_halt_match = (&(~(regs[8] ^ i_probe_addr) | regs[9])) & regs[12][8];
    assign o_halt_request_combined = req_sync_reg | i_halt_request_in;
    assign o_halt_acknowledge = i_core_ack | ctrl_reg[0];
    assign o_core_irq_gate = ~o_halt_acknowledge & ~ctrl_reg[2];
endmodule

// file: wdc_host_top_tb_top.sv
`timescale 1ns/100ps
module wdc_host_top_tb_top import wdc_pkg::*; ;
    logic i_core_clk, i_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000, o_wb_dat, rng = 32'h00016ada;
    logic o_wb_ack, o_tck, o_tms, o_tdi, tdo, hack, core_ack = 1'b0, req_in = 1'b0;
    logic req_comb, irq_gate, halt_match;
    logic [31:0] probe = 32'h00000000;
    int fails = 0, compares = 0;
    wdc_host_top #(.TCK_PHASES(4)) dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
        .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_tck(o_tck),
        .o_tms(o_tms), .o_tdi(o_tdi), .i_tdo(tdo), .i_halt_acknowledge(hack));
    wdc_dbg_model model_u (.i_rst(i_rst), .i_tck(o_tck), .i_tms(o_tms), .i_tdi(o_tdi),
        .i_core_ack(core_ack), .i_halt_request_in(req_in), .i_probe_addr(probe),
        .o_halt_match(halt_match), .o_tdo(tdo),
        .o_halt_acknowledge(hack), .o_halt_request_combined(req_comb),
        .o_core_irq_gate(irq_gate));
    // Core clock, 100 ns
    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Value the preset code should leave in the write-data register
    function automatic logic [31:0] exp_pre(input int c, input logic [31:0] w, s);
        case (c)
            0: return 32'h00000003;
            1: return 32'h00000001;
            2: return 32'hffffffff;
            3: return 32'h00000000;
            4: return 32'h000000f7;
            5: return 32'h00000100;
            6: return 32'h000000f0;
            7: return {w[15:0], w[15:0]};
            9: return s;
            10: return w | 32'h00000010;
            11: return {29'h0, w[2:0]} | 32'h00000108;
            default: return w;
        endcase
    endfunction
    task automatic report_and_stop();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk32(input string name, input logic [31:0] e, got);
        compares++;
        if (got !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, e, got);
        end
    endtask
    task automatic chkb(input string name, input logic e, got);
        compares++;
        if (got !== e) begin
            fails++;
            $display("unexpected %s expected %b seen %b", name, e, got);
        end
    endtask
    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        @(posedge i_core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge i_core_clk);
            if (o_wb_ack === 1'b1) break;
        end
        if (n == 50) begin
            fails++;
            report_and_stop();
        end
        q = o_wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h00000000, q);
    endtask
    // 38-bit access, or 4-bit instruction scan when ir is set; ends with done or refused, then clears both
    task automatic scan(input logic rw, input logic [4:0] a, input logic [31:0] d,
            output logic [31:0] q, st, input logic ir = 1'b0);
        int n;
        wr(OFF_WDATA, d);
        wr(OFF_CMD, {10'h000, 8'h02, ir ? 6'h03 : 6'h25, a, rw, ir, 1'b1});
        for (n = 0; n < 300; n++) begin
            rd(OFF_STATUS, st);
            if (st[STS_BUSY] === 1'b0 && (st[STS_DONE] | st[STS_REFUSED]) === 1'b1) break;
        end
        if (n == 300) begin
            fails++;
            report_and_stop();
        end
        rd(OFF_RDATA, q);
        wr(OFF_STATUS, 32'h00000006);
    endtask
    initial begin
        logic [31:0] q, st, d1, save;
        logic [4:0] a;
        int i;
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        for (i = 0; i < 100; i++) begin
            rd(OFF_STATUS, st);
            if (st[STS_BUSY] === 1'b0) break;
        end
        rd(OFF_CMD, q);
        chk32("cmd", 32'h00000000, q);
        rd(OFF_CFG, q);
        chk32("cfg", 32'h00000001, q);
        rd(8'h1c, q);
        chk32("unmapped", 32'h00000000, q);
        rd(OFF_PRESET, q);
        chk32("preset", 32'h00000000, q);
        // Read result of a scan shows up in the following scan
        scan(1'b0, 5'h00, rng, q, st);
        scan(1'b0, 5'h00, 32'h00000000, q, st);
        chk32("debug_control", 32'h00000000, q);
        chkb("halt_request_combined", 1'b0, req_comb);
        // Every control value, with the core running or halted
        for (i = 0; i < 8; i++) begin
            rng = xs(rng);
            core_ack <= rng[0];
            req_in <= rng[1];
            scan(1'b1, 5'h00, {rng[31:3], i[2:0]}, q, st);
            scan(1'b0, 5'h00, rng, q, st);
            scan(1'b0, 5'h00, rng, q, st);
            chk32("debug_control", {29'h0, i[2:0]}, q);
            chkb("halt_request_combined", i[1] | req_in, req_comb);
            rd(OFF_STATUS, st);
            chkb("halt_ack", core_ack | i[0], st[STS_HALT]);
            chkb("core_irq_gate", ~(core_ack | i[0]) & ~i[2], irq_gate);
        end
        // Instruction scan leaves the debug control register alone
        scan(1'b0, 5'h00, rng, q, st, 1'b1);
        chkb("ir_done", 1'b1, st[STS_DONE]);
        scan(1'b0, 5'h00, rng, q, st);
        chk32("debug_control", 32'h00000007, q);
        // Comparator writes only while halted
        scan(1'b1, 5'h00, 32'h00000000, q, st);
        rng = xs(rng);
        a = 5'h08 + {2'h0, rng[2:0]};
        d1 = xs(rng);
        core_ack <= 1'b1;
        scan(1'b1, a, d1, q, st);
        scan(1'b0, a, rng, q, st);
        scan(1'b0, a, rng, q, st);
        chk32("watch_reg", d1, q);
        core_ack <= 1'b0;
        scan(1'b1, a, ~d1, q, st);
        chkb("refused", 1'b1, st[STS_REFUSED]);
        chkb("done", 1'b0, st[STS_DONE]);
        core_ack <= 1'b1;
        scan(1'b0, a, rng, q, st);
        scan(1'b0, a, rng, q, st);
        chk32("watch_reg", d1, q);
        // Watchpoint 0 compare: masked bits match, enable gates the output
        scan(1'b1, 5'h08, d1, q, st);
        scan(1'b1, 5'h09, 32'h00000003, q, st);
        scan(1'b1, 5'h0c, 32'h00000100, q, st);
        probe <= d1 ^ 32'h00000003;
        @(posedge i_core_clk);
        chkb("halt_match", 1'b1, halt_match);
        probe <= d1 ^ 32'h00000004;
        @(posedge i_core_clk);
        chkb("halt_match", 1'b0, halt_match);
        scan(1'b1, 5'h0c, 32'h00000000, q, st);
        probe <= d1;
        @(posedge i_core_clk);
        chkb("halt_match", 1'b0, halt_match);
        // Every preset code plus one unused code
        save = 32'h00000000;
        for (i = 0; i < 13; i++) begin
            rng = xs(rng);
            wr(OFF_WDATA, rng);
            wr(OFF_PRESET, 32'(i));
            rd(OFF_WDATA, q);
            chk32("wdata", exp_pre(i, rng, save), q);
            if (i == 8) begin
                save = d1;
                rd(OFF_SAVE, q);
                chk32("save", save, q);
            end
        end
        report_and_stop();
    end
endmodule
